// ### hw/fsl_regs.sv
// module: fail-safe mapping and link configuration register bank
//
// Behaviour
// - offset 82h: bits 6-4 map F2..F0, bits 2-0 map E2..E0, 7 and 3 zero
// - offset 83h: bits 6-4 map H2..H0, bits 2-0 map G2..G0, 7 and 3 zero
// - every reset loads all writable fields from the nonvolatile image
// - watchdog code 0 disables watchdog; inactivity never forces fail-safe
// - watchdog codes 1..b select 200us up to 500ms timeouts
// - watchdog code c enters fail-safe at once, no waiting
// - break-wait codes 0..7 select 1ms,125us,250us,500us,1.25ms,2.5ms,5ms,5ms
// - bit 0 at 84h enables acknowledgement responses on the link
// - bit 4 at 85h chooses strap pins (0) or register address (1)
// - bits 3-0 at 85h hold programmed address, bits 7-5 read zero
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module fsl_regs (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       nv_valid_in,
  input  wire logic [7:0] nv_map_e_f_in,
  input  wire logic [7:0] nv_map_g_h_in,
  input  wire logic [7:0] nv_cfg_a_in,
  input  wire logic [7:0] nv_cfg_b_in,
  input  wire logic       address_strap_pin_0_in,
  input  wire logic       address_strap_pin_1_in,
  input  wire logic       address_strap_pin_2_in,
  input  wire logic       link_activity_in,
  input  wire logic       frame_end_in,
  output logic      [5:0] safe_map_e_f_out,
  output logic      [5:0] safe_map_g_h_out,
  output logic            ack_response_enable_out,
  output logic      [3:0] bus_address_out,
  output logic            failsafe_request_out,
  output logic            break_wait_done_out
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0] map_e_f_r;
  logic [7:0] map_e_f_nxt;
  logic [7:0] map_g_h_r;
  logic [7:0] map_g_h_nxt;
  logic [7:0] cfg_a_r;
  logic [7:0] cfg_a_nxt;
  logic [7:0] cfg_b_r;
  logic [7:0] cfg_b_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       loaded_r;
  logic       loaded_nxt;

  // strap and activity synchronisers
  logic [2:0] strap_s1_r;
  logic [2:0] strap_s2_r;
  logic       act_s1_r;
  logic       act_s2_r;
  logic       end_s1_r;
  logic       end_s2_r;

  // outputs
  logic [5:0] map_ef_out_r;
  logic [5:0] map_gh_out_r;
  logic       ack_out_r;
  logic [3:0] addr_out_r;
  logic       fs_out_r;
  logic       brk_out_r;

  // tick generator
  logic [7:0] tick_cnt_r;
  logic [7:0] tick_cnt_nxt;
  logic       tick_r;
  logic       tick_nxt;

  // timers
  logic [17:0] wdt_limit;
  logic [17:0] brk_limit;
  logic        wdt_en;
  logic        wdt_expired;
  logic        brk_expired;
  logic        brk_armed_r;
  logic        brk_armed_nxt;
  logic [3:0]  wdt_code;
  logic [2:0]  brk_code;

  assign wdt_code = cfg_a_r[fsl_pkg::WDT_POS +: 4];
  assign brk_code = cfg_a_r[fsl_pkg::BRK_POS +: 3];

  // ****************************************************************
  // register write and nonvolatile load
  // ****************************************************************
  always_comb begin
    map_e_f_nxt = map_e_f_r;
    map_g_h_nxt = map_g_h_r;
    cfg_a_nxt   = cfg_a_r;
    cfg_b_nxt   = cfg_b_r;
    loaded_nxt  = loaded_r;
    if (!loaded_r) begin
      if (nv_valid_in) begin
        map_e_f_nxt = nv_map_e_f_in & fsl_pkg::MAP_MASK;
        map_g_h_nxt = nv_map_g_h_in & fsl_pkg::MAP_MASK;
        cfg_a_nxt   = nv_cfg_a_in;
        cfg_b_nxt   = nv_cfg_b_in & fsl_pkg::CFG_B_MASK;
        loaded_nxt  = 1'b1;
      end
    end else if (wr_in) begin
      case (addr_in)
        fsl_pkg::OFS_SAFE_MAP_E_F: map_e_f_nxt = wdata_in & fsl_pkg::MAP_MASK;
        fsl_pkg::OFS_SAFE_MAP_G_H: map_g_h_nxt = wdata_in & fsl_pkg::MAP_MASK;
        fsl_pkg::OFS_LINK_CFG_A:   cfg_a_nxt   = wdata_in;
        fsl_pkg::OFS_LINK_CFG_B:   cfg_b_nxt   = wdata_in & fsl_pkg::CFG_B_MASK;
        default:                   cfg_a_nxt   = cfg_a_r;
      endcase
    end
  end

  // ****************************************************************
  // read mux, data one cycle after strobe
  // ****************************************************************
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_in) begin
      case (addr_in)
        fsl_pkg::OFS_SAFE_MAP_E_F: rdata_nxt = map_e_f_r;
        fsl_pkg::OFS_SAFE_MAP_G_H: rdata_nxt = map_g_h_r;
        fsl_pkg::OFS_LINK_CFG_A:   rdata_nxt = cfg_a_r;
        fsl_pkg::OFS_LINK_CFG_B:   rdata_nxt = cfg_b_r;
        fsl_pkg::OFS_LINK_STATUS:  rdata_nxt = {4'h0, addr_out_r[3], brk_out_r,
                                                fs_out_r, loaded_r};
        default:                   rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      map_e_f_r <= 8'h00;
      map_g_h_r <= 8'h00;
      cfg_a_r   <= 8'h00;
      cfg_b_r   <= 8'h00;
      loaded_r  <= 1'b0;
      rdata_r   <= 8'h00;
    end else begin
      map_e_f_r <= map_e_f_nxt;
      map_g_h_r <= map_g_h_nxt;
      cfg_a_r   <= cfg_a_nxt;
      cfg_b_r   <= cfg_b_nxt;
      loaded_r  <= loaded_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
      act_s1_r   <= 1'b0;
      act_s2_r   <= 1'b0;
      end_s1_r   <= 1'b0;
      end_s2_r   <= 1'b0;
    end else begin
      strap_s1_r <= {address_strap_pin_2_in, address_strap_pin_1_in, address_strap_pin_0_in};
      strap_s2_r <= strap_s1_r;
      act_s1_r   <= link_activity_in;
      act_s2_r   <= act_s1_r;
      end_s1_r   <= frame_end_in;
      end_s2_r   <= end_s1_r;
    end
  end

  // ****************************************************************
  // 5 us tick
  // ****************************************************************
  always_comb begin
    tick_cnt_nxt = tick_cnt_r + 8'h1;
    tick_nxt     = 1'b0;
    if (tick_cnt_r == 8'(fsl_pkg::TICK_CYCLES - 1)) begin
      tick_cnt_nxt = 8'h0;
      tick_nxt     = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_cnt_r <= 8'h0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  // ****************************************************************
  // timeout tables in ticks
  // ****************************************************************
  always_comb begin
    case (wdt_code)
      4'h1:    wdt_limit = 18'(fsl_pkg::WDT_US_1 / fsl_pkg::TICK_US);
      4'h2:    wdt_limit = 18'(fsl_pkg::WDT_US_2 / fsl_pkg::TICK_US);
      4'h3:    wdt_limit = 18'(fsl_pkg::WDT_US_3 / fsl_pkg::TICK_US);
      4'h4:    wdt_limit = 18'(fsl_pkg::WDT_US_4 / fsl_pkg::TICK_US);
      4'h5:    wdt_limit = 18'(fsl_pkg::WDT_US_5 / fsl_pkg::TICK_US);
      4'h6:    wdt_limit = 18'(fsl_pkg::WDT_US_6 / fsl_pkg::TICK_US);
      4'h7:    wdt_limit = 18'(fsl_pkg::WDT_US_7 / fsl_pkg::TICK_US);
      4'h8:    wdt_limit = 18'(fsl_pkg::WDT_US_8 / fsl_pkg::TICK_US);
      4'h9:    wdt_limit = 18'(fsl_pkg::WDT_US_9 / fsl_pkg::TICK_US);
      4'ha:    wdt_limit = 18'(fsl_pkg::WDT_US_A / fsl_pkg::TICK_US);
      4'hb:    wdt_limit = 18'(fsl_pkg::WDT_US_B / fsl_pkg::TICK_US);
      default: wdt_limit = 18'h1;
    endcase
  end

  always_comb begin
    case (brk_code)
      3'h0:    brk_limit = 18'(fsl_pkg::BRK_US_0 / fsl_pkg::TICK_US);
      3'h1:    brk_limit = 18'(fsl_pkg::BRK_US_1 / fsl_pkg::TICK_US);
      3'h2:    brk_limit = 18'(fsl_pkg::BRK_US_2 / fsl_pkg::TICK_US);
      3'h3:    brk_limit = 18'(fsl_pkg::BRK_US_3 / fsl_pkg::TICK_US);
      3'h4:    brk_limit = 18'(fsl_pkg::BRK_US_4 / fsl_pkg::TICK_US);
      3'h5:    brk_limit = 18'(fsl_pkg::BRK_US_5 / fsl_pkg::TICK_US);
      3'h6:    brk_limit = 18'(fsl_pkg::BRK_US_6 / fsl_pkg::TICK_US);
      default: brk_limit = 18'(fsl_pkg::BRK_US_7 / fsl_pkg::TICK_US);
    endcase
  end

  // watchdog only runs for codes 1..b after the load
  assign wdt_en = loaded_r && (wdt_code != fsl_pkg::WDT_OFF)
                  && (wdt_code <= fsl_pkg::WDT_LAST);

  // ****************************************************************
  // timers
  // ****************************************************************
  fsl_timer u_wdt (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .tick_in     (tick_r),
    .restart_in  (act_s2_r),
    .enable_in   (wdt_en),
    .limit_in    (wdt_limit),
    .expired_out (wdt_expired)
  );

  // break wait armed by a frame end, cleared by new activity; frame end wins a tie
  always_comb begin
    brk_armed_nxt = brk_armed_r;
    if (end_s2_r) begin
      brk_armed_nxt = 1'b1;
    end else if (act_s2_r) begin
      brk_armed_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      brk_armed_r <= 1'b0;
    end else begin
      brk_armed_r <= brk_armed_nxt;
    end
  end

  fsl_timer u_brk (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .tick_in     (tick_r),
    .restart_in  (act_s2_r),
    .enable_in   (brk_armed_r),
    .limit_in    (brk_limit),
    .expired_out (brk_expired)
  );

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      map_ef_out_r <= 6'h0;
      map_gh_out_r <= 6'h0;
      ack_out_r    <= 1'b0;
      addr_out_r   <= 4'h0;
      fs_out_r     <= 1'b0;
      brk_out_r    <= 1'b0;
    end else begin
      map_ef_out_r <= {map_e_f_r[6:4], map_e_f_r[2:0]};
      map_gh_out_r <= {map_g_h_r[6:4], map_g_h_r[2:0]};
      ack_out_r    <= cfg_a_r[fsl_pkg::ACK_POS];
      if (cfg_b_r[fsl_pkg::ADDR_SRC_POS]) begin
        addr_out_r <= cfg_b_r[fsl_pkg::ADDR_POS +: 4];
      end else begin
        addr_out_r <= {1'b0, strap_s2_r};
      end
      fs_out_r     <= (loaded_r && wdt_code == fsl_pkg::WDT_DIRECT)
                      || wdt_expired;
      brk_out_r    <= brk_expired;
    end
  end

  assign rdata_out               = rdata_r;
  assign safe_map_e_f_out        = map_ef_out_r;
  assign safe_map_g_h_out        = map_gh_out_r;
  assign ack_response_enable_out = ack_out_r;
  assign bus_address_out         = addr_out_r;
  assign failsafe_request_out    = fs_out_r;
  assign break_wait_done_out     = brk_out_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_map_reserved;
    @(posedge clk_in) disable iff (reset_in)
      (map_e_f_r[7] == 1'b0) && (map_e_f_r[3] == 1'b0)
      && (map_g_h_r[7] == 1'b0) && (map_g_h_r[3] == 1'b0);
  endproperty
  a_map_reserved: assert property (p_map_reserved)
    else $error("reserved map bit set");

  property p_map_write;
    @(posedge clk_in) disable iff (reset_in)
      (loaded_r && wr_in && addr_in == fsl_pkg::OFS_SAFE_MAP_G_H)
      |=> (map_g_h_r == ($past(wdata_in) & fsl_pkg::MAP_MASK));
  endproperty
  a_map_write: assert property (p_map_write)
    else $error("map write lost");

  property p_nv_load;
    @(posedge clk_in) disable iff (reset_in)
      (!loaded_r && nv_valid_in) |=> (loaded_r && cfg_a_r == $past(nv_cfg_a_in));
  endproperty
  a_nv_load: assert property (p_nv_load)
    else $error("nonvolatile load wrong");

  property p_wdt_off;
    @(posedge clk_in) disable iff (reset_in)
      (wdt_code == fsl_pkg::WDT_OFF) [*3] |-> !fs_out_r;
  endproperty
  a_wdt_off: assert property (p_wdt_off)
    else $error("fail-safe with watchdog off");

  property p_wdt_direct;
    @(posedge clk_in) disable iff (reset_in)
      (loaded_r && wdt_code == fsl_pkg::WDT_DIRECT) |=> fs_out_r;
  endproperty
  a_wdt_direct: assert property (p_wdt_direct)
    else $error("direct fail-safe missing");

  property p_wdt_timeout;
    @(posedge clk_in) disable iff (reset_in)
      (wdt_en && wdt_code == 4'h1 && act_s2_r) ##1 (!act_s2_r && wdt_code == 4'h1) [*8]
      |-> !fs_out_r;
  endproperty
  a_wdt_timeout: assert property (p_wdt_timeout)
    else $error("watchdog expired early");

  property p_ack;
    @(posedge clk_in) disable iff (reset_in)
      ##1 (ack_response_enable_out == $past(cfg_a_r[fsl_pkg::ACK_POS]));
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack enable mismatch");

  property p_addr_src;
    @(posedge clk_in) disable iff (reset_in)
      (cfg_b_r[fsl_pkg::ADDR_SRC_POS] == 1'b0) |=> (bus_address_out == {1'b0, $past(strap_s2_r)});
  endproperty
  a_addr_src: assert property (p_addr_src)
    else $error("strap address not used");

  property p_addr_reg;
    @(posedge clk_in) disable iff (reset_in)
      cfg_b_r[fsl_pkg::ADDR_SRC_POS] |=> (bus_address_out == $past(cfg_b_r[3:0]));
  endproperty
  a_addr_reg: assert property (p_addr_reg)
    else $error("register address not used");

  property p_cfg_b_read;
    @(posedge clk_in) disable iff (reset_in)
      (rd_in && addr_in == fsl_pkg::OFS_LINK_CFG_B) |=> (rdata_out[7:5] == 3'h0);
  endproperty
  a_cfg_b_read: assert property (p_cfg_b_read)
    else $error("reserved address bits read set");

  property p_brk_idle;
    @(posedge clk_in) disable iff (reset_in)
      !brk_armed_r [*2] |-> !break_wait_done_out;
  endproperty
  a_brk_idle: assert property (p_brk_idle)
    else $error("break wait done without frame end");

endmodule : fsl_regs

`default_nettype wire

// ### hw/fsl_pkg.sv
// package: register map, field layout and timing constants of the fail-safe/link config bank
package fsl_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_SAFE_MAP_E_F = 8'h82;
  localparam logic [7:0] OFS_SAFE_MAP_G_H = 8'h83;
  localparam logic [7:0] OFS_LINK_CFG_A   = 8'h84;
  localparam logic [7:0] OFS_LINK_CFG_B   = 8'h85;
  localparam logic [7:0] OFS_LINK_STATUS  = 8'h88;

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int        MAP_LO_POS    = 0;
  localparam int        MAP_HI_POS    = 4;
  localparam logic [7:0] MAP_MASK     = 8'h77;
  localparam int        WDT_POS       = 4;
  localparam int        BRK_POS       = 1;
  localparam int        ACK_POS       = 0;
  localparam int        ADDR_SRC_POS  = 4;
  localparam int        ADDR_POS      = 0;
  localparam logic [7:0] CFG_B_MASK   = 8'h1f;

  // ****************************************************************
  // watchdog codes
  // ****************************************************************
  localparam logic [3:0] WDT_OFF      = 4'h0;
  localparam logic [3:0] WDT_LAST     = 4'hb;
  localparam logic [3:0] WDT_DIRECT   = 4'hc;

  // ****************************************************************
  // timing: clock rate and tick base
  // ****************************************************************
  localparam int CLK_HZ        = 20000000;
  localparam int TICK_US       = 5;
  localparam int TICK_CYCLES   = CLK_HZ / 1000000 * TICK_US;

  // watchdog times in microseconds, codes 1 to b
  localparam int WDT_US_1 = 200;
  localparam int WDT_US_2 = 500;
  localparam int WDT_US_3 = 1000;
  localparam int WDT_US_4 = 2000;
  localparam int WDT_US_5 = 5000;
  localparam int WDT_US_6 = 10000;
  localparam int WDT_US_7 = 20000;
  localparam int WDT_US_8 = 50000;
  localparam int WDT_US_9 = 100000;
  localparam int WDT_US_A = 200000;
  localparam int WDT_US_B = 500000;

  // break-wait times in microseconds, codes 0 to 7
  localparam int BRK_US_0 = 1000;
  localparam int BRK_US_1 = 125;
  localparam int BRK_US_2 = 250;
  localparam int BRK_US_3 = 500;
  localparam int BRK_US_4 = 1250;
  localparam int BRK_US_5 = 2500;
  localparam int BRK_US_6 = 5000;
  localparam int BRK_US_7 = 5000;

endpackage : fsl_pkg

// ### hw/fsl_timer.sv
// module: inactivity timer counting ticks against a limit
`timescale 1ns/1ps
`default_nettype none

module fsl_timer (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        tick_in,
  input  wire logic        restart_in,
  input  wire logic        enable_in,
  input  wire logic [17:0] limit_in,
  output logic             expired_out
);

  logic [17:0] count_r;
  logic [17:0] count_nxt;
  logic        expired_r;
  logic        expired_nxt;

  // ****************************************************************
  // counter next state
  // ****************************************************************
  always_comb begin
    count_nxt   = count_r;
    expired_nxt = expired_r;
    if (restart_in || !enable_in) begin
      count_nxt   = 18'h0;
      expired_nxt = 1'b0;
    end else if (tick_in && !expired_r) begin
      count_nxt = count_r + 18'h1;
      if (count_nxt >= limit_in) begin
        expired_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_r   <= 18'h0;
      expired_r <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign expired_out = expired_r;

endmodule : fsl_timer

`default_nettype wire

// ### verif/fsl_host_model.sv
// host model: sends link frames of a given length, then flags the frame end
`timescale 1ns/1ps
`default_nettype none

module fsl_host_model (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       start_in,
  input  wire logic [7:0] len_in,
  output logic            activity_out,
  output logic            frame_end_out,
  output logic            busy_out
);
  logic [7:0] cnt_r, cnt_nxt;
  logic       busy_r, busy_nxt, end_r, end_nxt;

  // ****************************************************************
  // frame sequencer
  // ****************************************************************
  // next state: count frame cycles, pulse end for one cycle
  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    end_nxt  = 1'b0;
    if (start_in && !busy_r) begin
      busy_nxt = 1'b1;
      cnt_nxt  = len_in;
    end else if (busy_r) begin
      if (cnt_r == 8'h00) begin
        busy_nxt = 1'b0;
        end_nxt  = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 8'h01;
      end
    end
  end

  // state registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_r  <= 8'h00;
      busy_r <= 1'b0;
      end_r  <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      end_r  <= end_nxt;
    end
  end

  // traffic only inside frames, line quiet between them
  assign activity_out  = busy_r;
  assign frame_end_out = end_r;
  assign busy_out      = busy_r;
endmodule : fsl_host_model
`default_nettype wire

// ### verif/failsafe_map_link_config_regs_tb.sv
// testbench: register bank, reload, address source and link timers
`timescale 1ns/1ps
`default_nettype none

module failsafe_map_link_config_regs_tb;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } fsl_row_s;

  logic       clk_in, reset_in, wr_in, rd_in, nv_valid_in, start, frame_end, activity, busy;
  logic [7:0] addr_in, wdata_in, rdata_out, rd_val;
  logic [2:0] strap;
  logic [5:0] map_ef, map_gh;
  logic       ack, fs, brk_done;
  logic [3:0] bus_addr;
  int         fail_count, comparisons;
  // write, expected readback
  fsl_row_s   rows [0:6] = '{'{8'h82, 8'hff, 8'h77}, '{8'h83, 8'hff, 8'h77},
                             '{8'h83, 8'h5a, 8'h52}, '{8'h84, 8'ha5, 8'ha5},
                             '{8'h85, 8'hff, 8'h1f}, '{8'h86, 8'hff, 8'h00},
                             '{8'h82, 8'h08, 8'h00}};
  int         brk_us   [0:3] = '{fsl_pkg::BRK_US_1, fsl_pkg::BRK_US_2,
                                 fsl_pkg::BRK_US_3, fsl_pkg::BRK_US_0};
  logic [2:0] brk_code [0:3] = '{3'h1, 3'h2, 3'h3, 3'h0};

  fsl_regs dut (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .nv_valid_in(nv_valid_in),
    .nv_map_e_f_in(8'hff), .nv_map_g_h_in(8'h5a), .nv_cfg_a_in(8'h0b), .nv_cfg_b_in(8'hff),
    .address_strap_pin_0_in(strap[0]), .address_strap_pin_1_in(strap[1]),
    .address_strap_pin_2_in(strap[2]), .link_activity_in(activity),
    .frame_end_in(frame_end), .safe_map_e_f_out(map_ef), .safe_map_g_h_out(map_gh),
    .ack_response_enable_out(ack), .bus_address_out(bus_addr),
    .failsafe_request_out(fs), .break_wait_done_out(brk_done));

  fsl_host_model host (
    .clk_in(clk_in), .reset_in(reset_in), .start_in(start), .len_in(8'h14),
    .activity_out(activity), .frame_end_out(frame_end), .busy_out(busy));

  // ****************************************************************
  // bench tasks
  // ****************************************************************
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check_byte

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  // one host frame; returns about 9 cycles after its end
  task automatic frame();
    @(posedge clk_in);
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    cyc(30);
  endtask : frame

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // ****************************************************************
  // clock, watchdog, main sequence
  // ****************************************************************
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  initial begin
    #4ms;
    fail_count++;
    stop_test();
  end

  initial begin
    {reset_in, wr_in, rd_in, nv_valid_in, start} = 5'h10;
    {addr_in, wdata_in, strap} = '0;
    fail_count  = 0;
    comparisons = 0;
    cyc(16);
    check_byte("map_ef in reset", 8'h00, {2'b00, map_ef});
    reset_in <= 1'b0;
    // write before load must be lost
    wr(8'h84, 8'h55);
    rd(8'h84, rd_val);
    check_byte("write before load", 8'h00, rd_val);
    cyc(3);
    nv_valid_in <= 1'b1;
    cyc(4);
    rd(8'h84, rd_val);
    check_byte("cfg_a load", 8'h0b, rd_val);
    rd(8'h82, rd_val);
    check_byte("map_ef load", 8'h77, rd_val);
    rd(8'h83, rd_val);
    check_byte("map_gh load", 8'h52, rd_val);
    rd(8'h85, rd_val);
    check_byte("cfg_b load", 8'h1f, rd_val);
    check_byte("map_ef out", 8'h3f, {2'b00, map_ef});
    check_byte("map_gh out", 8'h2a, {2'b00, map_gh});
    check_byte("ack out", 8'h01, {7'h00, ack});
    check_byte("addr out", 8'h0f, {4'h0, bus_addr});
    // table of writes and readbacks
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rd_val);
      check_byte("readback", rows[i].exp, rd_val);
    end
    cyc(2);
    check_byte("map_ef out", 8'h00, {2'b00, map_ef});
    check_byte("map_gh out", 8'h2a, {2'b00, map_gh});
    wr(8'h84, 8'h01);
    cyc(3);
    check_byte("ack on", 8'h01, {7'h00, ack});
    wr(8'h84, 8'h00);
    cyc(3);
    check_byte("ack off", 8'h00, {7'h00, ack});
    // strap pins, then each programmed code
    strap <= 3'h5;
    wr(8'h85, 8'h00);
    cyc(5);
    check_byte("strap addr", 8'h05, {4'h0, bus_addr});
    for (int n = 0; n < 16; n++) begin
      wr(8'h85, 8'h10 | 8'(n));
      cyc(3);
      check_byte("prog addr", 8'(n), {4'h0, bus_addr});
    end
    // second reset reloads the image over written values
    reset_in <= 1'b1;
    cyc(2);
    reset_in <= 1'b0;
    cyc(6);
    rd(8'h82, rd_val);
    check_byte("map_ef reload", 8'h77, rd_val);
    // status: loaded set, address msb from reloaded image address f
    rd(8'h88, rd_val);
    check_byte("status reload", 8'h09, rd_val);
    // watchdog disabled, then direct entry, then 200us
    frame();
    cyc(5000);
    check_byte("wdt off", 8'h00, {7'h00, fs});
    wr(8'h84, 8'hc0);
    cyc(5);
    check_byte("wdt direct", 8'h01, {7'h00, fs});
    wr(8'h84, 8'h10);
    frame();
    check_byte("wdt cleared", 8'h00, {7'h00, fs});
    cyc(3800);
    check_byte("wdt early", 8'h00, {7'h00, fs});
    cyc(400);
    check_byte("wdt expiry", 8'h01, {7'h00, fs});
    wr(8'h84, 8'h00);
    cyc(3);
    check_byte("wdt disable", 8'h00, {7'h00, fs});
    // break-wait codes measured from the frame end
    foreach (brk_code[i]) begin
      wr(8'h84, {4'h0, brk_code[i], 1'b0});
      frame();
      cyc(brk_us[i] * 20 - 120);
      check_byte("brk early", 8'h00, {7'h00, brk_done});
      cyc(240);
      check_byte("brk done", 8'h01, {7'h00, brk_done});
    end
    stop_test();
  end
endmodule : failsafe_map_link_config_regs_tb
`default_nettype wire
